// *** design/pudc_counter.sv ***
// four-bit presettable up/down binary/decade counter with apb registers
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module pudc_counter
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_clock,
    output logic      [3:0]  count_value_out,
    output logic             terminal_carry_n
);

    // apb phase and address decode
    logic                    setup_phase;
    logic                    access_done;
    logic                    hit_ctrl;
    logic                    hit_preset;
    logic                    hit_status;
    logic                    hit_any;
    logic                    wr_ctrl;
    logic                    wr_preset;

    // apb response state
    logic [31:0]             read_word;
    logic [31:0]             next_prdata;
    logic                    next_pready;
    logic                    next_pslverr;

    // software-visible control and preset value
    pudc_pkg::pudc_ctrl_s    ctrl;
    pudc_pkg::pudc_ctrl_s    next_ctrl;
    logic [3:0]              preset_value_in;
    logic [3:0]              next_preset_value_in;

    // counter state
    logic                    count_edge;
    logic [3:0]              step_max;
    logic [3:0]              next_max;
    logic [3:0]              next_count;
    logic                    next_carry_n;

    // count clock pin is asynchronous, so it is synchronised first
    pudc_edge_sync u_edge_sync
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (count_clock),
        .rise_pulse (count_edge)
    );

    // a transfer completes only where the access phase meets ready
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign hit_ctrl    = (paddr == pudc_pkg::PUDC_CTRL_OFS);
    assign hit_preset  = (paddr == pudc_pkg::PUDC_PRESET_OFS);
    assign hit_status  = (paddr == pudc_pkg::PUDC_STATUS_OFS);
    assign hit_any     = hit_ctrl | hit_preset | hit_status;
    assign wr_ctrl     = access_done & pwrite & hit_ctrl;
    assign wr_preset   = access_done & pwrite & hit_preset;

    // read mux; status is taken in the setup cycle, so it is one clock old
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (hit_ctrl)
        begin
            read_word[pudc_pkg::PUDC_CTRL_LOAD_BIT] = ctrl.preset_load;
            read_word[pudc_pkg::PUDC_CTRL_ENN_BIT]  = ctrl.count_enable_n;
            read_word[pudc_pkg::PUDC_CTRL_BIN_BIT]  = ctrl.binary_mode;
            read_word[pudc_pkg::PUDC_CTRL_UP_BIT]   = ctrl.count_up;
        end
        else if (hit_preset)
        begin
            read_word[3:0] = preset_value_in;
        end
        else if (hit_status)
        begin
            read_word[pudc_pkg::PUDC_STAT_COUNT_LSB +: 4] = count_value_out;
            read_word[pudc_pkg::PUDC_STAT_CARRY_BIT]      = terminal_carry_n;
        end
    end

    // one wait-free access: ready is raised by the setup cycle
    always_comb
    begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase & ~hit_any;
        next_prdata  = prdata;
        if (setup_phase && !pwrite)
        begin
            next_prdata = read_word;
        end
    end

    // apb response registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // control and preset writes land at the completing access edge
    always_comb
    begin
        next_ctrl            = ctrl;
        next_preset_value_in = preset_value_in;
        if (wr_ctrl)
        begin
            next_ctrl.preset_load    = pwdata[pudc_pkg::PUDC_CTRL_LOAD_BIT];
            next_ctrl.count_enable_n = pwdata[pudc_pkg::PUDC_CTRL_ENN_BIT];
            next_ctrl.binary_mode    = pwdata[pudc_pkg::PUDC_CTRL_BIN_BIT];
            next_ctrl.count_up       = pwdata[pudc_pkg::PUDC_CTRL_UP_BIT];
        end
        if (wr_preset)
        begin
            next_preset_value_in = pwdata[3:0];
        end
    end

    // control registers; reset leaves the counter disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl            <= pudc_pkg::PUDC_CTRL_RST;
            preset_value_in <= pudc_pkg::PUDC_PRESET_RST;
        end
        else
        begin
            ctrl            <= next_ctrl;
            preset_value_in <= next_preset_value_in;
        end
    end

    // next count: preset wins, then an enabled count edge steps once
    always_comb
    begin
        step_max   = ctrl.binary_mode ? pudc_pkg::PUDC_MAX_BIN   // RULE4
                                      : pudc_pkg::PUDC_MAX_DEC;
        next_count = count_value_out;                            // RULE3
        if (ctrl.preset_load)
        begin
            // preset follows the value within one clock, not an edge
            next_count = preset_value_in;                        // RULE1
        end
        else if (!ctrl.count_enable_n && count_edge)             // RULE2
        begin
            if (ctrl.count_up)                                   // RULE5
            begin
                // a decade count above nine also wraps to zero
                if (count_value_out >= step_max)
                begin
                    next_count = pudc_pkg::PUDC_MIN;             // RULE7
                end
                else
                begin
                    next_count = count_value_out + 4'h1;
                end
            end
            else
            begin
                if (count_value_out == pudc_pkg::PUDC_MIN)
                begin
                    next_count = step_max;                       // RULE7
                end
                else
                begin
                    next_count = count_value_out - 4'h1;
                end
            end
        end
    end

    // carry is worked out from next values so it lines up with the count
    always_comb
    begin
        next_max = next_ctrl.binary_mode ? pudc_pkg::PUDC_MAX_BIN
                                         : pudc_pkg::PUDC_MAX_DEC;
        if (next_ctrl.count_enable_n)
        begin
            next_carry_n = 1'b1;                                 // RULE6
        end
        else if (next_ctrl.count_up)
        begin
            next_carry_n = (next_count != next_max);             // RULE6
        end
        else
        begin
            next_carry_n = (next_count != pudc_pkg::PUDC_MIN);   // RULE6
        end
    end

    // counter registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_value_out  <= pudc_pkg::PUDC_COUNT_RST;
            terminal_carry_n <= 1'b1;
        end
        else
        begin
            count_value_out  <= next_count;
            terminal_carry_n <= next_carry_n;
        end
    end

endmodule // pudc_counter

// *** design/pudc_pkg.sv ***
// shared constants and types for the presettable up/down counter
// Functional notes
// RULE1 - preset high copies preset value at once
// RULE2 - enabled and not preset: step one per clock
// RULE3 - preset low and enable high holds count
// RULE4 - base select high binary, low decimal
// RULE5 - direction high counts up, low down
// RULE6 - carry low at terminal value while enabled
// RULE7 - count wraps past terminal value per base
package pudc_pkg;

    // register byte offsets
    localparam logic [11:0] PUDC_CTRL_OFS   = 12'h000;
    localparam logic [11:0] PUDC_PRESET_OFS = 12'h004;
    localparam logic [11:0] PUDC_STATUS_OFS = 12'h008;

    // control field positions
    localparam int PUDC_CTRL_LOAD_BIT = 0;
    localparam int PUDC_CTRL_ENN_BIT  = 1;
    localparam int PUDC_CTRL_BIN_BIT  = 2;
    localparam int PUDC_CTRL_UP_BIT   = 3;

    // status field positions
    localparam int PUDC_STAT_COUNT_LSB = 0;
    localparam int PUDC_STAT_CARRY_BIT = 4;

    // terminal values
    localparam logic [3:0] PUDC_MAX_BIN = 4'hF;
    localparam logic [3:0] PUDC_MAX_DEC = 4'h9;
    localparam logic [3:0] PUDC_MIN     = 4'h0;

    // reset values
    localparam logic [3:0] PUDC_COUNT_RST  = 4'h0;
    localparam logic [3:0] PUDC_PRESET_RST = 4'h0;

    // synchroniser depth before edge detection
    localparam int PUDC_SYNC_STAGES = 2;

    // software control bits
    typedef struct packed {
        logic count_up;
        logic binary_mode;
        logic count_enable_n;
        logic preset_load;
    } pudc_ctrl_s;

    localparam pudc_ctrl_s PUDC_CTRL_RST = '{
        count_up:       1'b1,
        binary_mode:    1'b1,
        count_enable_n: 1'b1,
        preset_load:    1'b0
    };

endpackage

// *** design/pudc_edge_sync.sv ***
// two-stage synchroniser with rising edge pulse for the count clock pin
`timescale 1ns/1ps
module pudc_edge_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      rise_pulse
);

    logic [pudc_pkg::PUDC_SYNC_STAGES-1:0] sync_ff;
    logic                                  last_level;
    logic [pudc_pkg::PUDC_SYNC_STAGES-1:0] next_sync_ff;
    logic                                  next_last_level;
    logic                                  next_rise_pulse;

    // only the last stage feeds the edge detector
    always_comb
    begin
        next_sync_ff    = {sync_ff[pudc_pkg::PUDC_SYNC_STAGES-2:0], async_in};
        next_last_level = sync_ff[pudc_pkg::PUDC_SYNC_STAGES-1];
        next_rise_pulse = sync_ff[pudc_pkg::PUDC_SYNC_STAGES-1] & ~last_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_ff    <= '0;
            last_level <= 1'b0;
            rise_pulse <= 1'b0;
        end
        else
        begin
            sync_ff    <= next_sync_ff;
            last_level <= next_last_level;
            rise_pulse <= next_rise_pulse;
        end
    end

endmodule // pudc_edge_sync

// *** dv/pudc_sva.sv ***
// port checker for the counter
`timescale 1ns/1ps
module pudc_sva
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       terminal_carry_n,
    input wire logic [3:0] count_value_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    carry_value_a: assert property (!terminal_carry_n |->
        count_value_out inside {4'h0, 4'h9, 4'hF}) else $error("bad carry");
    reset_count_a: assert property ($rose(presetn) |->
        count_value_out == 4'h0) else $error("bad reset count");
    reset_carry_a: assert property ($rose(presetn) |->
        terminal_carry_n) else $error("bad reset carry");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held");
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("ready missing");
    ready_idle_a: assert property (!psel |=> !pready)
        else $error("ready while idle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // pudc_sva
bind pudc_counter pudc_sva i_sva (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .terminal_carry_n, .count_value_out);

// *** dv/pudc_clk_src.sv ***
// count clock source, still while idle
`timescale 1ns/1ps
module pudc_clk_src
(
    input  wire logic pclk,
    input  wire logic run,
    output logic      count_clock
);
    logic [2:0] d;
    // one rising edge per burst of six cycles
    always_ff @(posedge pclk) d <= run ? d + 3'h1 : 3'h0;
    assign count_clock = d[2];
endmodule // pudc_clk_src

// *** dv/pudc_counter_tb.sv ***
// bench for the counter
`timescale 1ns/1ps
module pudc_counter_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] rdata, got;
    logic [3:0] q;
    logic cc, rdy, err, carry_n, got_err;
    int n_fail = 0, checks = 0, cyc = 0;
    pudc_counter i_pudc_counter (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata(rdata), .pready(rdy), .pslverr(err),
        .count_clock(cc), .count_value_out(q), .terminal_carry_n(carry_n));
    pudc_clk_src i_pudc_clk_src (.pclk, .run, .count_clock(cc));
    initial forever #20 pclk = ~pclk;
    task close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk) if (++cyc > 9000)
    begin
        n_fail++;
        $display("mismatch timeout exp %0d seen %0d", 9000, cyc);
        close_out;
    end
    task chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; data and error taken at the ready edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {paddr, pwdata, pwrite, psel} <= {a, d, w, 1'b1};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (rdy !== 1'b1);
        got = rdata;
        got_err = err;
        {psel, penable} <= 2'b00;
    endtask
    // preset, release, one count edge, compare
    task t(input logic [3:0] c, p, e, input logic k);
        xfer(1, pudc_pkg::PUDC_PRESET_OFS, p);
        xfer(1, pudc_pkg::PUDC_CTRL_OFS, c | 4'h1);
        repeat (2) @(posedge pclk);
        chk("load q", p, q);
        chk("load carry", k, carry_n);
        xfer(1, pudc_pkg::PUDC_CTRL_OFS, c);
        run <= 1;
        repeat (6) @(posedge pclk);
        run <= 0;
        repeat (8) @(posedge pclk);
        chk("q", e, q);
        xfer(0, pudc_pkg::PUDC_STATUS_OFS, 0);
        chk("status q", e, got[3:0]);
        chk("status err", 0, got_err);
    endtask
    // reset in mid-run returns count, carry and control to reset values
    task mid_reset;
        xfer(1, pudc_pkg::PUDC_PRESET_OFS, 4'hF);
        xfer(1, pudc_pkg::PUDC_CTRL_OFS, 4'hD);
        repeat (2) @(posedge pclk);
        chk("pre-reset carry", 0, carry_n);
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk("reset q", pudc_pkg::PUDC_COUNT_RST, q);
        chk("reset carry", 1, carry_n);
        xfer(0, pudc_pkg::PUDC_CTRL_OFS, 0);
        chk("reset ctrl", pudc_pkg::PUDC_CTRL_RST, got[3:0]);
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk("idle carry", 1, carry_n);
        t(4'hC, 4'hF, 4'h0, 1'b0);
        t(4'h8, 4'h9, 4'h0, 1'b0);
        t(4'hC, 4'h9, 4'hA, 1'b1);
        t(4'h4, 4'h0, 4'hF, 1'b0);
        t(4'h0, 4'h5, 4'h4, 1'b1);
        t(4'h0, 4'h0, 4'h9, 1'b0);
        t(4'hC, 4'h7, 4'h8, 1'b1);
        t(4'hE, 4'h5, 4'h5, 1'b1);
        mid_reset;
        xfer(0, 12'h00C, 0);
        chk("unmapped err", 1, got_err);
        close_out;
    end
endmodule // pudc_counter_tb
